// ### rtl/uap_defs.svh
// Constants for the upper address port: widths, reset values, timing.
// Assumes inclusion by bare name from rtl files.
`ifndef UAP_DEFS_SVH
`define UAP_DEFS_SVH
`define UAP_WIDTH         8
`define UAP_ADDR_WIDTH    16
`define UAP_ADDR_LSB      8
`define UAP_LATCH_RESET   8'hFF
`define UAP_STRONG_CYCLES 1
`endif

// ### rtl/uap_pin_cell.sv
// One quasi-bidirectional port line with weak pull-up and strong kick.
// Assumes the pad resolves a weak pull-up when nothing drives it.
`timescale 1ns/1ps
`include "uap_defs.svh"
module uap_pin_cell (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic drive_value,
  input  wire logic addr_phase,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pull_up_en
);
  logic prev_value;
  logic strong_kick;

  // Remember last value driven so a rising edge can be spotted
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_value <= 1'b1;
    end else begin
      prev_value <= drive_value;
    end
  end

  // Strong drive high only on a 0->1 change in an address phase
  assign strong_kick = addr_phase & drive_value & ~prev_value;
  // Low is always driven; high relies on the pull-up unless kicked
  assign pin_out    = drive_value;
  assign pin_oe     = ~drive_value | strong_kick;
  assign pull_up_en = 1'b1;
endmodule

// ### rtl/uap_pkg.sv
// Types for the upper address port.
// Assumes uap_defs.svh is on the include path.
package uap_pkg;
  typedef enum logic [1:0] {
    UAP_SRC_LATCH,
    UAP_SRC_FETCH,
    UAP_SRC_WIDE_MOVE
  } uap_src_type;
endpackage

// ### rtl/uap_port.sv
// Upper address port: 8-line quasi-bidirectional port, address mux.
// Ones written to the latch float on the weak pull-up so the line can
// be read back, and zeros are driven hard. In address phases the upper
// address byte replaces the latch on the lines, and a line that rises
// gets one cycle of strong drive.
// Assumes the core sequencer supplies fetch/wide-move phase strobes
// synchronous to clk; pin inputs come from pads and are synchronised.
`timescale 1ns/1ps
`include "uap_defs.svh"
module uap_port
  import uap_pkg::*;
#(
  parameter int WIDTH = `UAP_WIDTH
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       latch_wr,
  input  wire logic [WIDTH-1:0]           latch_wdata,
  output logic      [WIDTH-1:0]           latch_rdata,
  output logic      [WIDTH-1:0]           pin_rdata,
  input  wire logic                       ext_fetch,
  input  wire logic                       external_move_wide_pointer,
  input  wire logic [`UAP_ADDR_WIDTH-1:0] bus_addr,
  input  wire logic [WIDTH-1:0]           upper_address_port_in,
  output logic      [WIDTH-1:0]           upper_address_port_out,
  output logic      [WIDTH-1:0]           upper_address_port_oe,
  output logic      [WIDTH-1:0]           upper_address_port_pullup
);
  logic [WIDTH-1:0] port_latch;
  logic [WIDTH-1:0] sync_a;
  logic [WIDTH-1:0] sync_b;
  logic [WIDTH-1:0] addr_byte;
  logic [WIDTH-1:0] drive_value;
  logic             addr_phase;
  uap_src_type      src;

  // Software latch; address phases never touch it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_latch <= `UAP_LATCH_RESET;
    end else if (latch_wr) begin
      port_latch <= latch_wdata;
    end
  end

  // Two-stage synchroniser on the pad inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= upper_address_port_in;
      sync_b <= sync_a;
    end
  end

  // Fetch takes precedence; both give the same byte anyway
  assign src = ext_fetch ? UAP_SRC_FETCH :
               external_move_wide_pointer ? UAP_SRC_WIDE_MOVE
                                          : UAP_SRC_LATCH;
  assign addr_phase = (src != UAP_SRC_LATCH);
  // Line n <- address bit 8+n, so the top line gets bit 15
  assign addr_byte = bus_addr[`UAP_ADDR_LSB +: WIDTH];
  assign drive_value = addr_phase ? addr_byte : port_latch;

  assign latch_rdata = port_latch;
  assign pin_rdata   = sync_b;

  // One cell per line
  for (genvar i = 0; i < WIDTH; i++) begin : g_line
    uap_pin_cell u_cell (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .drive_value (drive_value[i]),
      .addr_phase  (addr_phase),
      .pin_out     (upper_address_port_out[i]),
      .pin_oe      (upper_address_port_oe[i]),
      .pull_up_en  (upper_address_port_pullup[i])
    );
  end

  // Address phase drives every line whose address bit is zero
  a_addr_low_drive: assert property (
    @(posedge clk) disable iff (sys_rst)
    addr_phase |-> ((upper_address_port_oe & ~bus_addr[15:8]) ==
                    ~bus_addr[15:8]))
    else $error("address zero not driven");

  // Fetch shows the upper address byte in place of the latch
  a_fetch_byte_out: assert property (
    @(posedge clk) disable iff (sys_rst)
    ext_fetch |-> upper_address_port_out == bus_addr[15:8])
    else $error("fetch byte wrong");

  // Wide-pointer move alone shows the same byte
  a_wide_move_out: assert property (
    @(posedge clk) disable iff (sys_rst)
    (external_move_wide_pointer && !ext_fetch) |->
      upper_address_port_out == bus_addr[15:8])
    else $error("wide move byte wrong");

  // Top line rising in an address phase gets the strong drive
  a_rise_kick: assert property (
    @(posedge clk) disable iff (sys_rst)
    (addr_phase && $past(!sys_rst) && bus_addr[15] &&
     $past(drive_value[7]) == 1'b0) |-> upper_address_port_oe[7])
    else $error("no strong kick on rise");

  // Every line rising in an address phase is kicked, not just the top
  a_rise_kick_all: assert property (
    @(posedge clk) disable iff (sys_rst)
    (addr_phase && $past(!sys_rst)) |->
      ((upper_address_port_oe & bus_addr[15:8] & ~$past(drive_value)) ==
       (bus_addr[15:8] & ~$past(drive_value))))
    else $error("rising line missed kick");

  // Kick lasts one cycle: a steady value is left to the pull-up
  a_kick_one_cycle: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($past(!sys_rst) && drive_value == $past(drive_value)) |->
      ((upper_address_port_oe & upper_address_port_out) == '0))
    else $error("kick held too long");

  // Outside address phases no one is ever driven high
  a_no_latch_kick: assert property (
    @(posedge clk) disable iff (sys_rst)
    !addr_phase |-> ((upper_address_port_oe & upper_address_port_out) == '0))
    else $error("latch one driven high");

  // Line 7 carries address bit fifteen
  a_top_bit_map: assert property (
    @(posedge clk) disable iff (sys_rst)
    addr_phase |-> upper_address_port_out[7] == bus_addr[15])
    else $error("line 7 not bit 15");

  // Line 0 carries address bit eight
  a_bit_eight_map: assert property (
    @(posedge clk) disable iff (sys_rst)
    addr_phase |-> upper_address_port_out[0] == bus_addr[8])
    else $error("line 0 not bit 8");

  // Line 5 carries address bit thirteen
  a_bit_thirteen_map: assert property (
    @(posedge clk) disable iff (sys_rst)
    addr_phase |-> upper_address_port_out[5] == bus_addr[13])
    else $error("line 5 not bit 13");

  // Address phases leave the latch alone
  a_latch_kept: assert property (
    @(posedge clk) disable iff (sys_rst)
    (addr_phase && !latch_wr) |=> latch_rdata == $past(latch_rdata))
    else $error("latch changed by address");

  // Without a write the latch holds in any phase
  a_latch_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    !latch_wr |=> latch_rdata == $past(latch_rdata))
    else $error("latch changed without write");

  // A latch write lands one edge later
  a_latch_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    latch_wr |=> latch_rdata == $past(latch_wdata))
    else $error("latch write lost");

  // Latch value is back on the lines once the phase ends
  a_latch_restore: assert property (
    @(posedge clk) disable iff (sys_rst)
    !addr_phase |-> upper_address_port_out == latch_rdata)
    else $error("latch not restored");

  // Drive enables follow the latch outside address phases
  a_restore_oe: assert property (
    @(posedge clk) disable iff (sys_rst)
    !addr_phase |-> upper_address_port_oe == ~latch_rdata)
    else $error("latch enables not restored");

  // A latched one on line 0 is left to the pull-up
  a_one_released: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!addr_phase && latch_rdata[0]) |-> !upper_address_port_oe[0])
    else $error("one not left to pull-up");

  // A zero on any line is always actively driven
  a_low_driven: assert property (
    @(posedge clk) disable iff (sys_rst)
    (~upper_address_port_out & ~upper_address_port_oe) == '0)
    else $error("zero left undriven");

  // Weak pull-ups stay on for every line
  a_pullup_on: assert property (
    @(posedge clk) disable iff (sys_rst)
    upper_address_port_pullup == '1)
    else $error("pull-up off");

  // Reset leaves all ones in the latch
  a_reset_latch: assert property (
    @(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> latch_rdata == `UAP_LATCH_RESET)
    else $error("latch reset value wrong");

  // After reset the lines float, ready to be read
  a_reset_released: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($past(sys_rst) && !addr_phase) |-> upper_address_port_oe == '0)
    else $error("lines driven after reset");

  // Synchroniser comes out of reset cleared
  a_pin_reset: assert property (
    @(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> pin_rdata == '0)
    else $error("pin read not cleared");

  // Pad levels reach the read port two edges late
  a_pin_sync: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($past(!sys_rst) && $past(!sys_rst, 2)) |->
      pin_rdata == $past(upper_address_port_in, 2))
    else $error("pin read not two edges late");
endmodule

// ### test/testbench.sv
// Self-checking bench for the upper address port.
// Assumes the pad model closes the loop from pin drive to pad inputs.
`timescale 1ns/1ps
module testbench;
  logic        clk = 0, sys_rst = 1, latch_wr = 0, ext_fetch = 0, wide = 0;
  logic [7:0]  wdata = 8'h00, board_low = 8'h00, lat, pin, out, oe, pu, lvl;
  logic [15:0] addr = 16'h0000;
  int          fails = 0, n_tests = 0, cyc = 0;
  uap_port i_dut (.clk(clk), .sys_rst(sys_rst), .latch_wr(latch_wr),
    .latch_wdata(wdata), .latch_rdata(lat), .pin_rdata(pin),
    .ext_fetch(ext_fetch), .external_move_wide_pointer(wide),
    .bus_addr(addr), .upper_address_port_in(lvl),
    .upper_address_port_out(out), .upper_address_port_oe(oe),
    .upper_address_port_pullup(pu));
  uap_pad_model i_pad (.pad_out(out), .pad_oe(oe), .pad_pullup(pu),
    .board_low(board_low), .pad_level(lvl));
  initial forever #4 clk = ~clk;
  task automatic wrap_up();
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // A hang is cut off and failed after 300 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 300) begin
      fails++;
      wrap_up();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic write_latch(input logic [7:0] v);
    @(posedge clk) latch_wr <= 1'b1;
    wdata <= v;
    @(posedge clk) latch_wr <= 1'b0;
    #1;
  endtask
  task automatic drive_test();
    write_latch(8'h5A);
    check(lat, 8'h5A);
    check(out, 8'h5A);
    check(oe, 8'hA5);
  endtask
  // Rising address bits get a one-cycle kick; late write held back
  task automatic kick_test();
    @(posedge clk) ext_fetch <= 1'b1;
    addr <= 16'hA53C;
    #1 check(out, 8'hA5);
    check(oe, 8'hFF);
    @(posedge clk) latch_wr <= 1'b1;
    wdata <= 8'h0F;
    #1 check(oe, 8'h5A);
    @(posedge clk) latch_wr <= 1'b0;
    ext_fetch <= 1'b0;
    #1 check(out, 8'h0F);
    check(lat, 8'h0F);
  endtask
  // Walk a single one across every line
  task automatic wide_test();
    for (int n = 0; n < 8; n++) begin
      @(posedge clk) wide <= 1'b1;
      addr <= 16'h0001 << (8 + n);
      #1 check(out, 8'h01 << n);
    end
    @(posedge clk) wide <= 1'b0;
  endtask
  task automatic input_test();
    write_latch(8'hFF);
    check(oe, 8'h00);
    @(posedge clk) board_low <= 8'h81;
    repeat (3) @(posedge clk);
    #1 check(pin, 8'h7E);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    #1 check(lat, 8'hFF);
    check(oe, 8'h00);
    check(pu, 8'hFF);
    drive_test();
    kick_test();
    wide_test();
    input_test();
    wrap_up();
  end
endmodule

// ### test/uap_pad_model.sv
// Board side of the port: pads with pull-ups, board may pull lines low.
// Assumes oe high means the port drives the pad.
`timescale 1ns/1ps
module uap_pad_model (
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] board_low,
  output logic      [7:0] pad_level
);
  // Driven lines win; released lines rest high unless the board pulls low
  assign pad_level = (pad_oe & pad_out)
                   | (~pad_oe & ~board_low & pad_pullup);
endmodule
